//--- cfgd_decode.sv
/*
  configuration byte and security decoder.
  assumes the nonvolatile cells drive nv_cfg_byte and the security bits
  as steady levels, and power_up_capture pulses once after power-up.
*/
// Contract
// - a programmed (0) watchdog bit disables watchdog reset but leaves its interrupt usable.
// - a reset-pin-disable bit of 1 ignores the pin reset and makes the pin an input-only port.
// - ports reset high when the port-reset-level bit is 1 and low when it is 0.
// - a brownout bit of 1 picks the low trip level and 0 picks the high trip level.
// - the three-bit oscillator field picks external clock, rc, low, medium or high crystal.
// - with no security bit programmed both programming and verify are permitted.
// - with only security bit one programmed code programming stops but bit two may still be programmed.
// - with both security bits programmed verify and all programming are blocked.
// - a low-frequency crystal selection sets the low crystal range.
// - configuration is captured at power-up and software cannot change it later.
// - the program reads the configuration byte at its fixed external-data address.
module cfgd_decode (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // nonvolatile side
  input wire logic [7:0] nv_cfg_byte,
  input wire logic security_bit_one,
  input wire logic security_bit_two,
  input wire logic power_up_capture,
  // external-data read port
  input wire logic xdata_rd,
  input wire logic [15:0] xdata_addr,
  output logic [7:0] xdata_rdata,
  output logic xdata_hit,
  // programmer requests
  input wire logic prog_req,
  input wire logic verify_req,
  input wire logic sb2_prog_req,
  output logic prog_grant,
  output logic verify_grant,
  output logic sb2_prog_grant,
  // reset pin
  input wire logic reset_capable_port_pin,
  output logic ext_reset_req,
  output logic port_pin_in,
  // decoded controls
  output cfgd_pkg::cfgd_ctrl_s ctrl,
  output cfgd_pkg::cfgd_sec_s sec,
  output logic wdt_irq_only,
  output logic clk_en
);
  // ************************************
  // power-up capture
  // ************************************
  logic [7:0] system_config_byte_one;
  logic [7:0] next_cfg;
  logic captured;
  logic next_captured;
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic [7:0] next_rdata;
  logic next_hit;

  always_comb begin
    next_cfg = system_config_byte_one;
    next_captured = captured;
    if (power_up_capture && !captured) begin
      next_cfg = nv_cfg_byte;
      next_captured = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      system_config_byte_one <= cfgd_pkg::CFG_UNPROG_VALUE;
      captured <= 1'b0;
    end else begin
      system_config_byte_one <= next_cfg;
      captured <= next_captured;
    end
  end

  // ************************************
  // decode
  // ************************************
  logic watchdog_enable_cfg;
  logic reset_pin_disable_cfg;
  logic port_reset_level_cfg;
  logic brownout_level_select;
  logic clock_rate_select;
  logic [2:0] oscillator_type_select;

  assign watchdog_enable_cfg = system_config_byte_one[cfgd_pkg::CFG_WDT_BIT];
  assign reset_pin_disable_cfg = system_config_byte_one[cfgd_pkg::CFG_RPD_BIT];
  assign port_reset_level_cfg = system_config_byte_one[cfgd_pkg::CFG_PRL_BIT];
  assign brownout_level_select = system_config_byte_one[cfgd_pkg::CFG_BOV_BIT];
  assign clock_rate_select = system_config_byte_one[cfgd_pkg::CFG_CLOCK_RATE_SELECT_BIT];
  assign oscillator_type_select = system_config_byte_one[cfgd_pkg::CFG_OSC_LSB +: 3];

  always_comb begin
    ctrl.wdt_reset_en = watchdog_enable_cfg;
    ctrl.reset_pin_en = !reset_pin_disable_cfg;
    ctrl.port_reset_high = port_reset_level_cfg;
    ctrl.brownout_low_trip = brownout_level_select;
    ctrl.clk_div2 = !clock_rate_select;
    case (oscillator_type_select)
      cfgd_pkg::CFGD_OSC_HF_XTAL, cfgd_pkg::CFGD_OSC_MF_XTAL, cfgd_pkg::CFGD_OSC_LF_XTAL,
      cfgd_pkg::CFGD_OSC_RC, cfgd_pkg::CFGD_OSC_EXT_CLK: ctrl.osc_code = oscillator_type_select;
      // reserved codes fall back to the external clock
      default: ctrl.osc_code = cfgd_pkg::CFGD_OSC_EXT_CLK;
    endcase
    ctrl.lf_xtal_range = (oscillator_type_select == cfgd_pkg::CFGD_OSC_LF_XTAL);
  end

  assign wdt_irq_only = !watchdog_enable_cfg;
  assign ext_reset_req = !reset_pin_disable_cfg && !reset_capable_port_pin;
  assign port_pin_in = reset_pin_disable_cfg ? reset_capable_port_pin : 1'b1;

  // ************************************
  // security, bits read 0 when programmed
  // ************************************
  always_comb begin
    sec.prog_allow = security_bit_one && security_bit_two;
    sec.sb2_prog_allow = security_bit_two;
    sec.verify_allow = security_bit_one || security_bit_two;
    sec.bad_combo = security_bit_one && !security_bit_two;
  end

  assign prog_grant = prog_req && sec.prog_allow;
  assign verify_grant = verify_req && sec.verify_allow;
  assign sb2_prog_grant = sb2_prog_req && sec.sb2_prog_allow;

  // ************************************
  // clock enable divider and read port
  // ************************************
  always_comb begin
    next_div_cnt = div_cnt + 2'h1;
    if (!ctrl.clk_div2 || div_cnt == cfgd_pkg::CLK_DIV_COUNT - 2'h1) begin
      next_div_cnt = 2'h0;
    end
    next_hit = xdata_rd && (xdata_addr == cfgd_pkg::CFG_ONE_ADDR);
    next_rdata = next_hit ? system_config_byte_one : 8'h00;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 2'h0;
      xdata_rdata <= 8'h00;
      xdata_hit <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      xdata_rdata <= next_rdata;
      xdata_hit <= next_hit;
    end
  end

  // enable on count zero so a fresh divide starts with a tick
  assign clk_en = ctrl.clk_div2 ? (div_cnt == 2'h0) : 1'b1;

  // ************************************
  // checks
  // ************************************
  chk_capture_once: assert property (@(posedge core_clk) disable iff (!rst_n)
    captured && $stable(captured) |-> $stable(system_config_byte_one))
    else $error("config changed after capture");
  chk_capture_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    power_up_capture && !captured |=> system_config_byte_one == $past(nv_cfg_byte))
    else $error("config not captured");
  chk_wdt_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl.wdt_reset_en != wdt_irq_only) else $error("watchdog decode wrong");
  chk_pin_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    reset_pin_disable_cfg |-> !ext_reset_req) else $error("pin reset not ignored");
  chk_port_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl.port_reset_high == system_config_byte_one[5]) else $error("port level wrong");
  chk_bo_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl.brownout_low_trip == system_config_byte_one[4]) else $error("brownout select wrong");
  chk_prog_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
    !security_bit_one |-> !prog_grant) else $error("programming not locked");
  chk_verify_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
    !security_bit_one && !security_bit_two |-> !verify_grant && !sb2_prog_grant)
    else $error("verify not locked");
  chk_open_access: assert property (@(posedge core_clk) disable iff (!rst_n)
    security_bit_one && security_bit_two && prog_req && verify_req |-> prog_grant && verify_grant)
    else $error("open part refused");
  chk_div_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl.clk_div2 && $stable(ctrl.clk_div2) && clk_en |=> !clk_en)
    else $error("divider enable wrong");
  chk_cfg_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    xdata_rd && xdata_addr == 16'hfd00 |=> xdata_hit && xdata_rdata == $past(system_config_byte_one))
    else $error("config read wrong");
  chk_capture_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    captured |=> captured)
    else $error("capture flag dropped");
  chk_pin_port: assert property (@(posedge core_clk) disable iff (!rst_n)
    reset_pin_disable_cfg |-> port_pin_in == reset_capable_port_pin && !ctrl.reset_pin_en)
    else $error("reset pin not freed as port");
  chk_pin_active: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reset_pin_disable_cfg && !reset_capable_port_pin |-> ext_reset_req && port_pin_in)
    else $error("pin reset lost");
  chk_osc_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    oscillator_type_select inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7} |-> ctrl.osc_code == oscillator_type_select)
    else $error("oscillator code wrong");
  chk_lf_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl.lf_xtal_range == (oscillator_type_select == 3'h2))
    else $error("crystal range wrong");
  chk_sb2_open: assert property (@(posedge core_clk) disable iff (!rst_n)
    security_bit_two && sb2_prog_req |-> sb2_prog_grant)
    else $error("second bit programming refused");
  chk_verify_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    security_bit_two && verify_req |-> verify_grant)
    else $error("verify refused too early");
  chk_div_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctrl.clk_div2 |-> clk_en)
    else $error("undivided enable missing");
  chk_read_miss: assert property (@(posedge core_clk) disable iff (!rst_n)
    xdata_rd && xdata_addr != cfgd_pkg::CFG_ONE_ADDR |=> !xdata_hit && xdata_rdata == 8'h00)
    else $error("foreign read answered");

  cov_capture: cover property (@(posedge core_clk) disable iff (!rst_n) power_up_capture && !captured);
  cov_locked: cover property (@(posedge core_clk) disable iff (!rst_n) prog_req && !security_bit_one);
  cov_read: cover property (@(posedge core_clk) disable iff (!rst_n) xdata_hit);

  // ************************************
  // further coverage
  // ************************************
  cov_div2: cover property (@(posedge core_clk) disable iff (!rst_n) ctrl.clk_div2 && clk_en);
  cov_sb1_only: cover property (@(posedge core_clk) disable iff (!rst_n) !security_bit_one && sb2_prog_grant);
endmodule : cfgd_decode

//--- cfgd_pkg.sv
/*
  package for the configuration byte and security decoder.
  holds the field positions, the reset values, the config address
  and the enumerations shared with the decoder.
  assumes the nonvolatile cells are stable when the power-up capture is asked for.
*/
package cfgd_pkg;
  // ************************************
  // config byte one field positions
  // ************************************
  localparam int unsigned CFG_WDT_BIT = 7;
  localparam int unsigned CFG_RPD_BIT = 6;
  localparam int unsigned CFG_PRL_BIT = 5;
  localparam int unsigned CFG_BOV_BIT = 4;
  localparam int unsigned CFG_CLOCK_RATE_SELECT_BIT = 3;
  localparam int unsigned CFG_OSC_LSB = 0;
  localparam logic [7:0] CFG_UNPROG_VALUE = 8'hff;
  localparam logic [15:0] CFG_ONE_ADDR = 16'hfd00;
  localparam logic [1:0] CLK_DIV_COUNT = 2'h2;

  // ************************************
  // oscillator codes
  // ************************************
  typedef enum logic [2:0] {
    CFGD_OSC_HF_XTAL = 3'h0,
    CFGD_OSC_MF_XTAL = 3'h1,
    CFGD_OSC_LF_XTAL = 3'h2,
    CFGD_OSC_RC = 3'h3,
    CFGD_OSC_EXT_CLK = 3'h7
  } cfgd_osc_e;

  // ************************************
  // decoded controls to the rest of the chip
  // ************************************
  typedef struct packed {
    logic wdt_reset_en;
    logic reset_pin_en;
    logic port_reset_high;
    logic brownout_low_trip;
    logic clk_div2;
    logic [2:0] osc_code;
    logic lf_xtal_range;
  } cfgd_ctrl_s;

  typedef struct packed {
    logic prog_allow;
    logic sb2_prog_allow;
    logic verify_allow;
    logic bad_combo;
  } cfgd_sec_s;
endpackage : cfgd_pkg

//--- cfgd_far_model.sv
/*
  far-side model: port and timing logic fed by the decoded controls.
  assumes ctrl and clk_en come straight from the decoder.
*/
module cfgd_far_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // decoded controls
  input wire cfgd_pkg::cfgd_ctrl_s ctrl,
  input wire logic clk_en,
  // observed state
  output logic port_level,
  output logic [7:0] tick_count
);
  timeunit 1ns;
  timeprecision 1ns;
  assign port_level = ctrl.port_reset_high;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_count <= 8'h00;
    end else if (clk_en) begin
      tick_count <= tick_count + 8'h01;
    end
  end
endmodule : cfgd_far_model

//--- tb.sv
/*
  self-checking bench for the config decoder.
  assumes cfgd_pkg, cfgd_decode and cfgd_far_model are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst_n = 1'b0, sb1 = 1'b1, sb2 = 1'b1, cap = 1'b0, rd = 1'b0, pin = 1'b1;
  logic prq = 1'b0, vrq = 1'b0, srq = 1'b0;
  logic [7:0] nv = 8'hff, rdata, t0, d;
  logic [15:0] addr = 16'h0000;
  logic hit, pg, vg, sg, ext_rst, pin_in, irq_only, clk_en, port_level, h;
  logic [7:0] ticks;
  cfgd_pkg::cfgd_ctrl_s ctrl;
  cfgd_pkg::cfgd_sec_s sec;
  int n_errors = 0;
  int n_checks = 0;
  logic [7:0] tbl [5] = '{8'hff, 8'h7b, 8'ha2, 8'h51, 8'h88};
  // sb2/sb1 pairs; the unsupported 0/1 pair is never produced
  logic [1:0] sec_tbl [3] = '{2'h3, 2'h2, 2'h0};
  logic [2:0] sec_exp [3] = '{3'h7, 3'h3, 3'h0};

  cfgd_decode cfgd_decode_i (.core_clk(core_clk), .rst_n(rst_n), .nv_cfg_byte(nv), .security_bit_one(sb1),
    .security_bit_two(sb2), .power_up_capture(cap), .xdata_rd(rd), .xdata_addr(addr), .xdata_rdata(rdata),
    .xdata_hit(hit), .prog_req(prq), .verify_req(vrq), .sb2_prog_req(srq), .prog_grant(pg),
    .verify_grant(vg), .sb2_prog_grant(sg), .reset_capable_port_pin(pin), .ext_reset_req(ext_rst),
    .port_pin_in(pin_in), .ctrl(ctrl), .sec(sec), .wdt_irq_only(irq_only), .clk_en(clk_en));
  cfgd_far_model cfgd_far_model_i (.core_clk(core_clk), .rst_n(rst_n), .ctrl(ctrl), .clk_en(clk_en),
    .port_level(port_level), .tick_count(ticks));

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  function automatic cfgd_pkg::cfgd_ctrl_s exp_ctrl(input logic [7:0] b);
    cfgd_pkg::cfgd_ctrl_s c;
    c = {b[7], ~b[6], b[5], b[4], ~b[3], b[2:0], b[2:0] == 3'h2};
    return c;
  endfunction : exp_ctrl

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic capture(input logic [7:0] b);
    @(posedge core_clk);
    nv <= b;
    cap <= 1'b1;
    @(posedge core_clk);
    cap <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask : capture

  task automatic rd_byte(input logic [15:0] a, output logic [7:0] dv, output logic hv);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    dv = rdata;
    hv = hit;
  endtask : rd_byte

  initial begin
    #5000000;
    n_errors++;
    $display("timeout");
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    chk("reset ctrl", {7'h00, exp_ctrl(cfgd_pkg::CFG_UNPROG_VALUE)}, {7'h00, ctrl});
    foreach (tbl[i]) begin
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      capture(tbl[i]);
      chk("ctrl", {7'h00, exp_ctrl(tbl[i])}, {7'h00, ctrl});
      chk("irq only", {15'h0, ~tbl[i][7]}, {15'h0, irq_only});
      chk("port level", {15'h0, tbl[i][5]}, {15'h0, port_level});
      rd_byte(cfgd_pkg::CFG_ONE_ADDR, d, h);
      chk("cfg read", {7'h00, h, tbl[i]}, {7'h00, h, d});
      chk("cfg hit", 16'h1, {15'h0, h});
      rd_byte(16'hfd01, d, h);
      chk("other read", 16'h0, {7'h00, h, d});
      capture(~tbl[i]);
      chk("late capture", {7'h00, exp_ctrl(tbl[i])}, {7'h00, ctrl});
      @(posedge core_clk);
      pin <= 1'b0;
      @(posedge core_clk);
      #1;
      chk("pin", {14'h0, ~tbl[i][6], ~tbl[i][6]}, {14'h0, ext_rst, pin_in});
      t0 = ticks;
      @(posedge core_clk);
      pin <= 1'b1;
      repeat (7) @(posedge core_clk);
      #1;
      chk("ticks", tbl[i][3] ? 16'h8 : 16'h4, {8'h00, ticks - t0});
      $display("test config %h done", tbl[i]);
    end
    foreach (sec_tbl[i]) begin
      @(posedge core_clk);
      {sb2, sb1} <= sec_tbl[i];
      {prq, vrq, srq} <= 3'h7;
      @(posedge core_clk);
      #1;
      chk("grants", {13'h0, sec_exp[i]}, {13'h0, pg, vg, sg});
      chk("sec", {12'h0, sec_exp[i][2], sec_exp[i][0], sec_exp[i][1], 1'b0}, {12'h0, sec});
    end
    $display("test security done");
    report_and_stop();
  end
endmodule : tb
